// ### core/flash_ctl_cfg.svh
// constants for the lock and power-down command interpreter
`ifndef FLASH_CTL_CFG_SVH
`define FLASH_CTL_CFG_SVH

// ============================================================
// opcodes
`define OP_GLOBAL_LOCK    8'h7E
`define OP_GLOBAL_UNLOCK  8'h98
`define OP_LOCK_QUERY_A   8'h3C
`define OP_LOCK_QUERY_B   8'h3D
`define OP_SLEEP_SELECT   8'hB9
`define OP_SLEEP_DEEPEST  8'h79
`define OP_WAKE           8'hAB
`define OP_RESET_ENABLE   8'h66
`define OP_RESET_DEVICE   8'h99
`define OP_TERMINATE      8'hF0
`define OP_PROG_PAGE      8'h02
`define OP_PROG_SEQ_A     8'hAF
`define OP_PROG_SEQ_B     8'hAD
`define OP_PROG_DUAL      8'hA2
`define OP_PROG_QUAD      8'h32
`define OP_PROG_SECURITY  8'h9B
`define OP_ERASE_4K       8'h20
`define OP_ERASE_32K      8'h52
`define OP_ERASE_64K      8'hD8
`define OP_ERASE_CHIP_A   8'h60
`define OP_ERASE_CHIP_B   8'hC7

// ============================================================
// register offsets (byte addresses)
`define REG_STATUS_THREE  8'h00
`define REG_STATUS_FOUR   8'h04
`define REG_DEVICE_STATE  8'h08

// ============================================================
// field positions
`define BIT_RESET_PIN_EN  7
`define BIT_PROTECT_SEL   2
`define BIT_POWER_DOWN    7
`define LOCK_FIELD_LSB    0
`define BLOCK_ADDR_LSB    16
`define ADDR_BYTES        2'h3
`define FIELD_BITS        4'h8

// ============================================================
// reset values
`define STATUS_THREE_RST  8'h00
`define STATUS_FOUR_RST   8'h00

// ============================================================
// timing: recovery times in ns, clock period in ns
`define CLK_PERIOD_NS     40
`define LIGHT_REC_NS      10000
`define DEEP_REC_NS       100000
`define LIGHT_REC_CYC     ((`LIGHT_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEEP_REC_CYC      ((`DEEP_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_TIME_CYC       1000

`endif

// ### core/flash_ctl_pkg.sv
// types for the lock and power-down command interpreter
package flash_ctl_pkg;

	// ============================================================
	// power state of the device
	typedef enum logic [2:0]
	{
		MODE_ACTIVE,
		MODE_LIGHT,
		MODE_DEEP,
		MODE_RECOVER
	} power_mode_e;

	// ============================================================
	// command decoder state within one chip-select frame
	typedef enum logic [1:0]
	{
		DEC_OPCODE,
		DEC_ADDR,
		DEC_SHIFT,
		DEC_DONE
	} decode_e;

	// ============================================================
	// status bundle presented on the state register
	typedef struct packed
	{
		logic       busy;
		logic       refused;
		logic       in_light;
		logic       in_deep;
		logic       recovering;
		logic [2:0] resv;
	} dev_state_s;

endpackage : flash_ctl_pkg

// ### core/flash_ctl.sv
// lock and power-down command interpreter of a serial flash
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"

module flash_ctl
	import flash_ctl_pkg::*;
#(
	parameter int BLK_W   = 6,             // block index width
	parameter int OP_CYC  = `OP_TIME_CYC   // program/erase duration
)
(
	input  wire logic       i_mclk,        // system clock
	input  wire logic       i_reset_n,     // power-on reset
	input  wire logic       i_cs_n,        // spi chip select
	input  wire logic       i_byte_valid,  // one received byte
	input  wire logic [7:0] i_byte,        // received byte value
	input  wire logic       i_bit_tick,    // serial output shift
	input  wire logic       i_jedec_reset, // jedec reset pulse
	input  wire logic       i_reset_pin,   // reset pin, active high
	input  wire logic [7:0] i_addr,        // register address
	input  wire logic [7:0] i_wdata,       // register write data
	input  wire logic       i_wr,          // register write strobe
	input  wire logic       i_rd,          // register read strobe
	output logic      [7:0] o_rdata,       // register read data
	output logic            o_so,          // serial data output
	output logic            o_so_oe,       // serial output enable
	output logic            o_busy         // operation in progress
);

	// ============================================================
	// declarations
	localparam logic [7:0] LIGHT_CYC = 8'(`LIGHT_REC_CYC);
	localparam int         CNT_W     = 16;

	logic [7:0]           status_three_q;  // reset pin en, protect sel
	logic [7:0]           status_four_q;   // power down select
	logic [2**BLK_W-1:0]  lock_q;          // one lock bit per block
	power_mode_e          mode_q;          // sleep state
	decode_e              dec_q;           // frame decoder
	logic [7:0]           opcode_q;        // opcode of this frame
	logic [1:0]           addr_cnt_q;      // address bytes seen
	logic [23:0]          addr_q;          // collected address
	logic [7:0]           shift_q;         // lock field shifter
	logic [3:0]           bit_cnt_q;       // bits left to shift
	logic                 rst_en_q;        // 66h armed
	logic [CNT_W-1:0]     op_cnt_q;        // operation timer
	logic [CNT_W-1:0]     rec_cnt_q;       // recovery timer
	logic                 refused_q;       // last program/erase refused
	logic                 so_q;
	logic                 so_oe_q;
	logic [7:0]           rdata_q;

	logic                 op_byte;         // opcode byte arrives
	logic                 addr_done;       // last address byte arrives
	logic                 is_query;
	logic                 is_prog_erase;
	logic                 is_chip_erase;
	logic                 sw_reset;
	logic                 pin_reset;
	logic                 dev_reset;       // any device reset
	logic                 deep_wake;       // ABh from deepest sleep
	logic                 accept;          // opcode is honoured
	logic                 protect_on;
	logic [23:0]          full_addr;       // address incl. last byte
	logic [BLK_W-1:0]     blk;
	logic                 blk_locked;
	logic                 chip_locked;
	dev_state_s           state;

	// ============================================================
	// opcode classification
	always_comb
	begin
		is_query      = (i_byte == `OP_LOCK_QUERY_A) ||
		                (i_byte == `OP_LOCK_QUERY_B);
		is_chip_erase = (i_byte == `OP_ERASE_CHIP_A) ||
		                (i_byte == `OP_ERASE_CHIP_B);
		is_prog_erase = (i_byte == `OP_PROG_PAGE) ||
		                (i_byte == `OP_PROG_SEQ_A) ||
		                (i_byte == `OP_PROG_SEQ_B) ||
		                (i_byte == `OP_PROG_DUAL) ||
		                (i_byte == `OP_PROG_QUAD) ||
		                (i_byte == `OP_PROG_SECURITY) ||
		                (i_byte == `OP_ERASE_4K) ||
		                (i_byte == `OP_ERASE_32K) ||
		                (i_byte == `OP_ERASE_64K);
	end

	// ============================================================
	// acceptance: sleep and busy filter what the decoder honours
	always_comb
	begin
		op_byte = i_byte_valid && !i_cs_n && (dec_q == DEC_OPCODE);
		unique case (mode_q)
			MODE_ACTIVE:  accept = o_busy ?
			                (i_byte == `OP_TERMINATE ||
			                 i_byte == `OP_RESET_ENABLE ||
			                 i_byte == `OP_RESET_DEVICE) : 1'b1;
			MODE_LIGHT:   accept = (i_byte == `OP_WAKE) ||
			                (i_byte == `OP_RESET_ENABLE) ||
			                (i_byte == `OP_RESET_DEVICE);
			MODE_DEEP:    accept = (i_byte == `OP_WAKE);
			// host must wait out recovery, nothing is taken meanwhile
			MODE_RECOVER: accept = 1'b0;
			default:      accept = 1'b0;
		endcase
	end

	// ============================================================
	// reset sources; the pin only counts when software enabled it
	always_comb
	begin
		pin_reset = i_reset_pin &&
		            status_three_q[`BIT_RESET_PIN_EN];
		sw_reset  = op_byte && accept && rst_en_q &&
		            (i_byte == `OP_RESET_DEVICE);
		deep_wake = op_byte && accept && (mode_q == MODE_DEEP) &&
		            (i_byte == `OP_WAKE);
		// all of these abort a running operation and reset state
		dev_reset = i_jedec_reset || pin_reset || sw_reset ||
		            deep_wake;
		addr_done = i_byte_valid && !i_cs_n && (dec_q == DEC_ADDR) &&
		            (addr_cnt_q == 2'(`ADDR_BYTES - 2'h1));
	end

	// ============================================================
	// protection lookup for the addressed block
	always_comb
	begin
		protect_on  = status_three_q[`BIT_PROTECT_SEL];
		full_addr   = {addr_q[15:0], i_byte};
		blk         = full_addr[`BLOCK_ADDR_LSB +: BLK_W];
		blk_locked  = protect_on && lock_q[blk];
		chip_locked = protect_on && (|lock_q);
		state       = '{busy:       o_busy,
		                refused:    refused_q,
		                in_light:   (mode_q == MODE_LIGHT),
		                in_deep:    (mode_q == MODE_DEEP),
		                recovering: (mode_q == MODE_RECOVER),
		                resv:       3'h0};
	end

	// ============================================================
	// frame decoder; chip select high always restarts it
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || dev_reset || i_cs_n)
		begin
			dec_q      <= DEC_OPCODE;
			opcode_q   <= 8'h00;
			addr_cnt_q <= 2'h0;
			addr_q     <= 24'h00_0000;
		end
		else if (i_byte_valid)
		begin
			unique case (dec_q)
				DEC_OPCODE:
				begin
					opcode_q <= i_byte;
					// address phase only for commands actually honoured
					dec_q    <= (accept && mode_q == MODE_ACTIVE &&
					             (is_query || is_prog_erase)) ?
					            DEC_ADDR : DEC_DONE;
				end
				DEC_ADDR:
				begin
					addr_q     <= {addr_q[15:0], i_byte};
					addr_cnt_q <= addr_cnt_q + 2'h1;
					if (addr_done)
						dec_q <= (opcode_q == `OP_LOCK_QUERY_A ||
						          opcode_q == `OP_LOCK_QUERY_B) ?
						         DEC_SHIFT : DEC_DONE;
				end
				DEC_SHIFT: dec_q <= DEC_SHIFT;
				DEC_DONE:  dec_q <= DEC_DONE;
			endcase
		end
	end

	// ============================================================
	// serial output of the lock field, msb first
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || dev_reset || i_cs_n)
		begin
			shift_q   <= 8'h00;
			bit_cnt_q <= 4'h0;
			so_q      <= 1'b0;
			so_oe_q   <= 1'b0;
		end
		else if (addr_done && (opcode_q == `OP_LOCK_QUERY_A ||
		                       opcode_q == `OP_LOCK_QUERY_B))
		begin
			// field holds the effective lock in its lsb
			shift_q   <= {7'h00, blk_locked};
			bit_cnt_q <= `FIELD_BITS;
			so_oe_q   <= 1'b1;
		end
		else if (i_bit_tick && bit_cnt_q != 4'h0)
		begin
			so_q      <= shift_q[7];
			shift_q   <= {shift_q[6:0], 1'b0};
			bit_cnt_q <= bit_cnt_q - 4'h1;
		end
	end

	// ============================================================
	// power mode; a chip select rise alone changes nothing here
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			mode_q    <= MODE_ACTIVE;
			rec_cnt_q <= '0;
		end
		else if (deep_wake)
		begin
			mode_q    <= MODE_RECOVER;
			rec_cnt_q <= CNT_W'(`DEEP_REC_CYC);
		end
		else if (i_jedec_reset || pin_reset || sw_reset)
		begin
			mode_q    <= MODE_ACTIVE;
			rec_cnt_q <= '0;
		end
		else if (mode_q == MODE_RECOVER)
		begin
			if (rec_cnt_q <= CNT_W'(1))
				mode_q <= MODE_ACTIVE;
			rec_cnt_q <= rec_cnt_q - CNT_W'(1);
		end
		else if (op_byte && accept)
		begin
			if (mode_q == MODE_ACTIVE && !o_busy &&
			    i_byte == `OP_SLEEP_SELECT)
				mode_q <= status_four_q[`BIT_POWER_DOWN] ?
				          MODE_LIGHT : MODE_DEEP;
			else if (mode_q == MODE_ACTIVE && !o_busy &&
			         i_byte == `OP_SLEEP_DEEPEST)
				mode_q <= MODE_DEEP;
			else if (mode_q == MODE_LIGHT && i_byte == `OP_WAKE)
			begin
				// wake keeps contents, only a short recovery
				mode_q    <= MODE_RECOVER;
				rec_cnt_q <= CNT_W'(LIGHT_CYC);
			end
		end
	end

	// ============================================================
	// software reset arming: only the next accepted opcode may fire it
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || dev_reset)
			rst_en_q <= 1'b0;
		else if (op_byte && accept)
			rst_en_q <= (i_byte == `OP_RESET_ENABLE);
	end

	// ============================================================
	// block locks; default all set, effective only with select bit
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || dev_reset)
			lock_q <= '1;
		else if (op_byte && accept && mode_q == MODE_ACTIVE && !o_busy)
		begin
			if (i_byte == `OP_GLOBAL_LOCK)
				lock_q <= '1;
			else if (i_byte == `OP_GLOBAL_UNLOCK)
				lock_q <= '0;
		end
	end

	// ============================================================
	// program/erase timer: resets abort, terminate just halts
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || dev_reset)
		begin
			op_cnt_q  <= '0;
			refused_q <= 1'b0;
		end
		else if (op_byte && accept && o_busy &&
		         i_byte == `OP_TERMINATE)
			op_cnt_q <= '0;
		else if (op_byte && accept && !o_busy && is_chip_erase &&
		         mode_q == MODE_ACTIVE)
		begin
			refused_q <= chip_locked;
			op_cnt_q  <= chip_locked ? '0 : CNT_W'(OP_CYC);
		end
		else if (addr_done && opcode_q != `OP_LOCK_QUERY_A &&
		         opcode_q != `OP_LOCK_QUERY_B)
		begin
			refused_q <= blk_locked;
			op_cnt_q  <= blk_locked ? '0 : CNT_W'(OP_CYC);
		end
		else if (op_cnt_q != '0)
			op_cnt_q <= op_cnt_q - CNT_W'(1);
	end

	// ============================================================
	// register port: status bits survive device resets
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			status_three_q <= `STATUS_THREE_RST;
			status_four_q  <= `STATUS_FOUR_RST;
		end
		else if (i_wr && i_addr == `REG_STATUS_THREE)
			status_three_q <= i_wdata;
		else if (i_wr && i_addr == `REG_STATUS_FOUR)
			status_four_q  <= i_wdata;
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || !i_rd)
			rdata_q <= 8'h00;
		else
		begin
			unique case (i_addr)
				`REG_STATUS_THREE: rdata_q <= status_three_q;
				`REG_STATUS_FOUR:  rdata_q <= status_four_q;
				`REG_DEVICE_STATE: rdata_q <= state;
				default:           rdata_q <= 8'h00;
			endcase
		end
	end

	// busy as a flop so the output comes straight from a register
	logic busy_q;
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			busy_q <= 1'b0;
		else
			busy_q <= (op_cnt_q != '0);
	end

	assign o_busy  = busy_q;
	assign o_rdata = rdata_q;
	assign o_so    = so_q;
	assign o_so_oe = so_oe_q;

endmodule : flash_ctl

// ### verif/spi_host_model.sv
// spi host model that frames opcodes for the interpreter
`timescale 1ns/1ps
module spi_host_model
(
	input  wire logic       i_mclk,  // system clock
	input  wire logic       i_so,    // device serial output
	input  wire logic       i_so_oe, // device drives output
	output logic            o_cs_n,  // chip select
	output logic            o_valid, // byte strobe
	output logic      [7:0] o_byte,  // byte value
	output logic            o_tick   // output shift tick
);
	// ============================================================
	// idle bus
	initial
	begin
		o_cs_n = 1'b1;
		o_valid = 1'b0;
		o_byte = 8'h00;
		o_tick = 1'b0;
	end

	// ============================================================
	// opcode then n address bytes, msb byte first
	task automatic frame(input logic [7:0] op, input int n,
		input logic [23:0] a);
		logic [31:0] w;
		w = {op, a};
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		for (int i = 0; i <= n; i++)
		begin
			@(posedge i_mclk);
			o_valid <= 1'b1;
			o_byte <= w[31 - 8 * i -: 8];
		end
		@(posedge i_mclk);
		o_valid <= 1'b0;
		// released byte lane never repeats the stale value
		o_byte <= ~o_byte;
	endtask : frame

	// one opcode per frame, so 66h and 99h go apart
	task automatic close();
		@(posedge i_mclk);
		o_cs_n <= 1'b1;
	endtask : close

	// ============================================================
	// clock out the lock field, one tick per bit
	task automatic fetch(output logic [7:0] f, output logic ok);
		f = 8'h00;
		@(posedge i_mclk);
		#1 ok = i_so_oe;
		repeat (8)
		begin
			@(posedge i_mclk);
			o_tick <= 1'b1;
			@(posedge i_mclk);
			o_tick <= 1'b0;
			#1 f = {f[6:0], i_so};
		end
	endtask : fetch
endmodule : spi_host_model

// ### verif/flash_ctl_monitor.sv
// assertion checker for the lock and power-down interpreter
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
module flash_ctl_monitor
#(
	parameter int OP_CYC = `OP_TIME_CYC // program/erase duration
)
(
	input wire logic       i_mclk,
	input wire logic       i_reset_n,
	input wire logic       i_cs_n,
	input wire logic       i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic       i_bit_tick,
	input wire logic       i_jedec_reset,
	input wire logic       i_reset_pin,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       o_so,
	input wire logic       o_so_oe,
	input wire logic       o_busy
);
	// ============================================================
	// frame tracking
	logic       take;     // byte accepted in a frame
	logic       qhit;     // last address byte of a query
	logic [2:0] cnt_q;    // byte index within frame
	logic [7:0] op_q;     // opcode of current or last frame
	logic       pin_en_q; // reset pin armed by software
	logic [3:0] tk_q;     // ticks since output enable
	int         bsy_q;    // busy run length
	assign take = i_byte_valid && !i_cs_n;
	assign qhit = take && cnt_q == 3'h3 &&
		(op_q == `OP_LOCK_QUERY_A || op_q == `OP_LOCK_QUERY_B);
	// byte counter restarts whenever chip select rises
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || i_cs_n) cnt_q <= 3'h0;
		else if (take && cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
	end
	// opcode kept past the frame to see the 66h/99h pair
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n) op_q <= 8'h00;
		else if (take && cnt_q == 3'h0) op_q <= i_byte;
	end
	// status three is kept over device resets, so a mirror works
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n) pin_en_q <= 1'b0;
		else if (i_wr && i_addr == `REG_STATUS_THREE)
			pin_en_q <= i_wdata[`BIT_RESET_PIN_EN];
	end
	// tick and busy counters
	always_ff @(posedge i_mclk)
	begin
		if (!o_so_oe) tk_q <= 4'h0;
		else if (i_bit_tick) tk_q <= tk_q + 4'h1;
		bsy_q <= (o_busy && i_reset_n) ? bsy_q + 1 : 0;
	end

	// ============================================================
	// properties
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence busy_drops;
		##[1:3] !o_busy;
	endsequence
	AST_SO_RELEASE: assert property (i_cs_n |=> !o_so_oe)
		else $error("output enable held after chip select");
	AST_QUERY_ORIGIN: assert property ($rose(o_so_oe) |-> $past(qhit))
		else $error("output enabled without a query");
	AST_SO_HOLD: assert property (o_so_oe && $past(o_so_oe) &&
		!$past(i_bit_tick) |-> $stable(o_so))
		else $error("serial output moved without a tick");
	AST_SO_ZEROS: assert property (o_so_oe && i_bit_tick && !i_cs_n &&
		tk_q < 4'h6 |=> o_so == 1'b0)
		else $error("upper lock field bits not zero");
	AST_F0_HALT: assert property (take && cnt_q == 3'h0 && o_busy &&
		i_byte == `OP_TERMINATE |-> busy_drops)
		else $error("terminate did not halt operation");
	AST_SOFT_ABORT: assert property (take && cnt_q == 3'h0 && o_busy &&
		i_byte == `OP_RESET_DEVICE && op_q == `OP_RESET_ENABLE
		|-> busy_drops)
		else $error("software reset did not abort");
	AST_JEDEC_ABORT: assert property (i_jedec_reset && o_busy |=>
		##[0:2] !o_busy)
		else $error("jedec reset did not abort");
	AST_PIN_ABORT: assert property (i_reset_pin && pin_en_q && o_busy
		|-> busy_drops)
		else $error("reset pin did not abort");
	AST_BUSY_LENGTH: assert property (bsy_q <= OP_CYC + 2)
		else $error("operation ran too long");
	cover property ($rose(o_so_oe));
	cover property ($fell(o_busy));
	cover property (i_jedec_reset && o_busy);
	cover property (i_reset_pin && pin_en_q && o_busy);
endmodule : flash_ctl_monitor

bind flash_ctl flash_ctl_monitor #(.OP_CYC(OP_CYC)) u_flash_ctl_monitor
(
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
	.i_byte_valid(i_byte_valid), .i_byte(i_byte),
	.i_bit_tick(i_bit_tick), .i_jedec_reset(i_jedec_reset),
	.i_reset_pin(i_reset_pin), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_so(o_so),
	.o_so_oe(o_so_oe), .o_busy(o_busy)
);

// ### verif/tb_flash_ctl.sv
// self-checking bench for the lock and power-down interpreter
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	bad_count++; $display("[ERR] %0t got %h want %h", $time, a, b); \
	end end
module tb_flash_ctl;
	logic        mclk = 1'b0;  // system clock
	logic        rst_n;        // power-on reset
	logic        cs_n, bval;   // frame controls from the host
	logic        tick, so;     // serial output path
	logic        so_oe, busy;  // device outputs
	logic        jed, pin;     // reset events
	logic        wr, rd;       // register strobes
	logic  [7:0] bdat, addr;   // byte lane and register address
	logic  [7:0] wdata, rdata; // register data
	logic  [7:0] v, f;         // scratch values
	logic        ok;           // output enable seen
	logic [31:0] seed = 32'h0000_9755; // stimulus lfsr
	int          bad_count, comparisons, n;
	logic  [7:0] ops [11] = '{8'h02, 8'hAF, 8'hAD, 8'hA2, 8'h32,
		8'h9B, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};

	always #20 mclk = ~mclk;

	flash_ctl #(.OP_CYC(20)) u_flash_ctl
	(
		.i_mclk(mclk), .i_reset_n(rst_n), .i_cs_n(cs_n),
		.i_byte_valid(bval), .i_byte(bdat), .i_bit_tick(tick),
		.i_jedec_reset(jed), .i_reset_pin(pin), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_so(so), .o_so_oe(so_oe), .o_busy(busy)
	);
	spi_host_model u_spi_host_model
	(
		.i_mclk(mclk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
		.o_valid(bval), .o_byte(bdat), .o_tick(tick)
	);

	// ============================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg
	// read data is taken in the single cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd <= 1'b1; addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task automatic cmd(input logic [7:0] op);
		u_spi_host_model.frame(op, 0, 24'h00_0000);
		u_spi_host_model.close();
	endtask : cmd
	// one-cycle reset event: jedec when j is set, else the reset pin
	task automatic pulse(input logic j);
		@(posedge mclk);
		jed <= j;
		pin <= !j;
		@(posedge mclk);
		jed <= 1'b0;
		pin <= 1'b0;
	endtask : pulse
	// query with a random address; both opcodes are used
	task automatic query(input logic e);
		seed = lfsr(seed);
		u_spi_host_model.frame(seed[24] ? `OP_LOCK_QUERY_A :
			`OP_LOCK_QUERY_B, 3, seed[23:0]);
		u_spi_host_model.fetch(f, ok);
		`CHK(ok, 1'b1)
		`CHK(f, {7'h00, e})
		u_spi_host_model.close();
	endtask : query
	task automatic wait_busy(input logic lvl);
		n = 0;
		while (busy !== lvl && n < 100) begin @(posedge mclk); #1 n++; end
		`CHK(busy, lvl)
	endtask : wait_busy
	// polls state until idle, n counts cycles spent
	task automatic wait_idle();
		n = 0;
		v = 8'hFF;
		while (v !== 8'h00 && n < 6000) begin rreg(8'h08, v); n += 2; end
		`CHK(v, 8'h00)
	endtask : wait_idle
	task automatic wrap_up();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ============================================================
	// hang guard, well past the longest recovery
	initial
	begin
		#2_000_000;
		bad_count++;
		wrap_up();
	end

	// ============================================================
	// main sequence
	initial
	begin
		{rst_n, jed, pin, wr, rd} = 5'h00;
		{addr, wdata} = 16'h0000;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		wreg(8'h0C, seed[7:0]);
		for (int i = 0; i < 16; i += 4)
		begin
			rreg(i[7:0], v);
			`CHK(v, 8'h00)
		end
		query(1'b0);
		wreg(8'h00, 8'h84);
		query(1'b1);
		cmd(`OP_GLOBAL_UNLOCK);
		query(1'b0);
		cmd(`OP_GLOBAL_LOCK);
		query(1'b1);
		cmd(`OP_ERASE_CHIP_A);
		rreg(8'h08, v);
		`CHK(v[7:6], 2'b01)
		for (int i = 0; i < 11; i++)
		begin
			cmd(`OP_GLOBAL_UNLOCK);
			seed = lfsr(seed);
			u_spi_host_model.frame(ops[i], (i > 8) ? 0 : 3, seed[23:0]);
			u_spi_host_model.close();
			wait_busy(1'b1);
			case (i % 4)
				0: cmd(`OP_TERMINATE);
				1:
				begin
					cmd(`OP_RESET_ENABLE);
					cmd(`OP_RESET_DEVICE);
				end
				2: pulse(1'b1);
				default: pulse(1'b0);
			endcase
			wait_busy(1'b0);
			query(i % 4 != 0);
		end
		// light sleep keeps locks; stray opcodes and frames ignored
		cmd(`OP_GLOBAL_UNLOCK);
		wreg(8'h04, 8'h80);
		cmd(`OP_SLEEP_SELECT);
		cmd(`OP_TERMINATE);
		cmd(`OP_GLOBAL_LOCK);
		rreg(8'h08, v);
		`CHK(v[5:4], 2'b10)
		cmd(`OP_WAKE);
		wait_idle();
		`CHK(n >= 200 && n <= 400, 1'b1)
		query(1'b0);
		cmd(`OP_SLEEP_SELECT);
		cmd(`OP_RESET_ENABLE);
		cmd(`OP_RESET_DEVICE);
		wait_idle();
		query(1'b1);
		// deepest sleep ignores the software reset pair
		wreg(8'h04, 8'h00);
		cmd(`OP_SLEEP_SELECT);
		cmd(`OP_RESET_ENABLE);
		cmd(`OP_RESET_DEVICE);
		cmd(`OP_TERMINATE);
		rreg(8'h08, v);
		`CHK(v[5:4], 2'b01)
		cmd(`OP_WAKE);
		wait_idle();
		`CHK(n >= 2400 && n <= 2700, 1'b1)
		wreg(8'h04, 8'h80);
		cmd(`OP_SLEEP_DEEPEST);
		rreg(8'h08, v);
		`CHK(v[5:4], 2'b01)
		pulse(1'b1);
		wait_idle();
		cmd(`OP_SLEEP_DEEPEST);
		pulse(1'b0);
		wait_idle();
		cmd(`OP_SLEEP_SELECT);
		@(posedge mclk) rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rreg(8'h04, v);
		`CHK(v, 8'h00)
		wait_idle();
		wrap_up();
	end
endmodule : tb_flash_ctl
